// ### src/dcd_pkg.sv
package dcd_pkg;

  // ---------------------------------------------------------------
  // Clock and execution unit
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int UNIT_CLOCKS     = 12;
  // Half units exist in the timing table, so counts are in half units
  localparam int HALF_UNIT_CLKS  = UNIT_CLOCKS / 2;

  // ---------------------------------------------------------------
  // Command byte fields
  // ---------------------------------------------------------------
  localparam int CMD_DIR_BIT     = 3;
  localparam int CMD_INC_BIT     = 0;
  localparam logic [7:0] CMD_VSM_SET   = 8'h99;
  localparam logic [7:0] CMD_VSM_CLEAR = 8'h95;
  localparam logic [7:0] CMD_INC_ROW   = 8'hB0;
  localparam logic [3:0] NIB_CHAR40    = 4'h0;
  localparam logic [3:0] NIB_CHAR8     = 4'h4;
  localparam logic [3:0] NIB_CHAR12    = 4'h5;
  localparam logic [1:0] SUB_24BIT     = 2'h0;
  localparam logic [1:0] SUB_16BIT     = 2'h1;

  // ---------------------------------------------------------------
  // Execution times in half units (write / read)
  // ---------------------------------------------------------------
  localparam logic [4:0] HT_ONE        = 5'h02;
  localparam logic [4:0] HT_INC_ROW    = 5'h04;
  localparam logic [4:0] HT_C24_WR     = 5'h08;
  localparam logic [4:0] HT_C24_RD     = 5'h0F;
  localparam logic [4:0] HT_C16_WR     = 5'h0B;
  localparam logic [4:0] HT_C16_RD     = 5'h0F;
  localparam logic [4:0] HT_C8_WR      = 5'h12;
  localparam logic [4:0] HT_C8_RD      = 5'h13;
  localparam logic [4:0] HT_C12_WR     = 5'h19;
  localparam logic [4:0] HT_C12_RD     = 5'h17;

  // ---------------------------------------------------------------
  // Pointer and status layout
  // ---------------------------------------------------------------
  localparam int PTR_Y_LSB       = 8;
  localparam int PTR_Y_W         = 5;
  localparam int PTR_X_W         = 6;
  localparam logic [5:0] LAST_COLUMN   = 6'h27;
  localparam int ST_BUSY         = 7;
  localparam int ST_ALARM        = 6;
  localparam int ST_LAST_COL     = 5;
  localparam int ST_VSYNC        = 2;
  localparam logic [15:0] MP_RESET     = 16'h0000;

  typedef enum logic [2:0] {
    DCD_IDLE  = 3'b001,
    DCD_RUN   = 3'b010,
    DCD_DONE  = 3'b100
  } dcd_state_t;

endpackage

// ### src/dcd_timer.sv
`timescale 1ns/10ps
`default_nettype none
module dcd_timer
  import dcd_pkg::*;
(
  input  wire logic       i_mclk,   // Device clock
  input  wire logic       i_nrst,   // Async reset, low
  input  wire logic       i_load,   // Start a new count
  input  wire logic [4:0] i_halves, // Duration in half units
  input  wire logic       i_hold,   // Suspend counting
  output logic            o_done    // One-cycle end pulse
);

  typedef struct packed {
    logic [4:0] halves;
    logic [3:0] clocks;
    logic       run;
    logic       done;
  } dcd_tmr_t;

  dcd_tmr_t st;
  dcd_tmr_t next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (i_load) begin
      next_st.halves = i_halves;
      next_st.clocks = 4'(HALF_UNIT_CLKS - 1);
      next_st.run    = 1'b1;
    end else if (st.run && !i_hold) begin
      if (st.clocks != 4'h0) begin
        next_st.clocks = st.clocks - 4'h1;
      end else if (st.halves <= 5'h01) begin
        next_st.run  = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.halves = st.halves - 5'h01;
        next_st.clocks = 4'(HALF_UNIT_CLKS - 1);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_done = st.done;

endmodule // dcd_timer
`default_nettype wire

// ### src/dcd_status.sv
`timescale 1ns/10ps
`default_nettype none
module dcd_status
  import dcd_pkg::*;
(
  input  wire logic i_mclk,        // Device clock
  input  wire logic i_nrst,        // Async reset, low
  input  wire logic i_mask_set,    // Set mask pulse
  input  wire logic i_mask_clear,  // Clear mask pulse
  input  wire logic i_vsync,       // Raw sync state
  output logic      o_mask,        // Mask state
  output logic      o_vsync_status // Gated status bit
);

  typedef struct packed {
    logic mask;
    logic stat;
  } dcd_vst_t;

  dcd_vst_t st;
  dcd_vst_t next_st;

  always_comb begin
    next_st = st;
    if (i_mask_set) begin
      next_st.mask = 1'b1;
    end else if (i_mask_clear) begin
      next_st.mask = 1'b0;
    end
    // Mask gates the raw state; raw is low two lines per frame
    next_st.stat = next_st.mask ? 1'b0 : i_vsync;
  end

  // Reset value is arbitrary since software must set or clear first
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_mask         = st.mask;
  assign o_vsync_status = st.stat;

endmodule // dcd_status
`default_nettype wire

// ### src/dcd_decoder.sv
// Overview of operation
// - Increment-row adds one to the row field of the main pointer, other fields unchanged.
// - A sync mask bit is set by the mask-set command and cleared by the mask-clear command.
// - While the mask is set the sync status bit reads zero.
// - While the mask is clear the sync status bit follows the internal sync state.
// - Unmasked, the status bit is zero for two lines per frame and one otherwise.
// - The sync status bit is part of the status byte the host reads.
// - The 24-bit 40-column transfer decodes as 0000 d 00 i, takes 4 units write, 7.5 read.
// - The 16-bit 40-column transfer decodes as 0000 d 01 i, takes 5.5 write, 7.5 read.
// - The 8-bit 80-column transfer decodes as 0100 d 00 i, takes 9 write, 9.5 read.
// - The 12-bit 80-column transfer decodes as 0101 d 00 i, takes 12.5 write, 11.5 read.
// - Byte 99h is mask-set, one unit, argument registers untouched.
// - Byte 95h is mask-clear, one unit, argument registers untouched.
// - Execution starts at strobe trailing edge only if selected with request bit set.
// - The sync state appears at status bit two, subject to the mask.
`timescale 1ns/10ps
`default_nettype none
module dcd_decoder
  import dcd_pkg::*;
(
  input  wire logic        i_mclk,          // Device clock
  input  wire logic        i_nrst,          // Async reset, low
  input  wire logic        i_cmd_valid,     // Strobe trailing edge with command
  input  wire logic        i_selected,      // Latched select at address strobe
  input  wire logic        i_exec_req,      // Latched request bit
  input  wire logic [7:0]  i_cmd,           // Command byte
  input  wire logic        i_vsync,         // Internal sync state
  input  wire logic        i_suspend,       // Memory bus not available
  input  wire logic        i_mp_load,       // Load main pointer
  input  wire logic [15:0] i_mp_data,       // Main pointer load value
  output logic [15:0]      o_main_pointer,  // Main pointer
  output logic [7:0]       o_status,        // Status byte
  output logic             o_busy,          // Execution in progress
  output logic             o_mem_start,     // Start of memory transfer
  output logic [2:0]       o_xfer_kind,     // 0 none,1 c24,2 c16,3 c8,4 c12
  output logic             o_xfer_read,     // Direction of transfer
  output logic             o_vsync_mask,    // Mask state
  output logic             o_done           // Command completion pulse
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dcd_state_t  fsm;
    logic [15:0] mp;
    logic [7:0]  status;
    logic        mem_start;
    logic [2:0]  kind;
    logic        rd;
    logic        inc_row;
    logic        inc_col;
    logic        use_mem;
    logic        done;
  } dcd_dec_t;

  dcd_dec_t st;
  dcd_dec_t next_st;

  logic       accept;
  logic       mask_set;
  logic       mask_clear;
  logic       tmr_load;
  logic [4:0] tmr_halves;
  logic       tmr_done;
  logic       vmask;
  logic       vstat;
  logic [5:0] col;

  assign accept     = i_cmd_valid && i_selected && i_exec_req;
  assign mask_set   = accept && (i_cmd == CMD_VSM_SET);
  assign mask_clear = accept && (i_cmd == CMD_VSM_CLEAR);
  assign col        = st.mp[PTR_X_W-1:0];

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  always_comb begin
    next_st           = st;
    next_st.mem_start = 1'b0;
    next_st.done      = 1'b0;
    tmr_load          = 1'b0;
    tmr_halves        = HT_ONE;
    if (i_mp_load && !st.status[ST_BUSY]) begin
      next_st.mp = i_mp_data;
    end
    if (accept) begin
      // New command aborts any one in progress
      tmr_load                  = 1'b1;
      next_st.fsm               = DCD_RUN;
      next_st.status[ST_BUSY]   = 1'b1;
      next_st.status[6:3]       = 4'h0;
      next_st.kind              = 3'h0;
      next_st.rd                = i_cmd[CMD_DIR_BIT];
      next_st.inc_row           = 1'b0;
      next_st.inc_col           = i_cmd[CMD_INC_BIT];
      next_st.use_mem           = 1'b0;
      if (i_cmd == CMD_INC_ROW) begin
        next_st.inc_row = 1'b1;
        tmr_halves      = HT_INC_ROW;
      end else if (i_cmd[7:4] == NIB_CHAR40 && i_cmd[2:1] == SUB_24BIT) begin
        next_st.kind    = 3'h1;
        next_st.use_mem = 1'b1;
        tmr_halves      = i_cmd[CMD_DIR_BIT] ? HT_C24_RD : HT_C24_WR;
      end else if (i_cmd[7:4] == NIB_CHAR40 && i_cmd[2:1] == SUB_16BIT) begin
        next_st.kind    = 3'h2;
        next_st.use_mem = 1'b1;
        tmr_halves      = i_cmd[CMD_DIR_BIT] ? HT_C16_RD : HT_C16_WR;
      end else if (i_cmd[7:4] == NIB_CHAR8 && i_cmd[2:1] == SUB_24BIT) begin
        next_st.kind    = 3'h3;
        next_st.use_mem = 1'b1;
        tmr_halves      = i_cmd[CMD_DIR_BIT] ? HT_C8_RD : HT_C8_WR;
      end else if (i_cmd[7:4] == NIB_CHAR12 && i_cmd[2:1] == SUB_24BIT) begin
        next_st.kind    = 3'h4;
        next_st.use_mem = 1'b1;
        tmr_halves      = i_cmd[CMD_DIR_BIT] ? HT_C12_RD : HT_C12_WR;
      end
      next_st.mem_start = next_st.use_mem;
    end else begin
      case (st.fsm)
        DCD_IDLE: begin
          next_st.fsm = DCD_IDLE;
        end
        DCD_RUN: begin
          if (tmr_done) begin
            next_st.fsm = DCD_DONE;
          end
        end
        DCD_DONE: begin
          if (st.inc_row) begin
            next_st.mp[PTR_Y_LSB +: PTR_Y_W] =
              st.mp[PTR_Y_LSB +: PTR_Y_W] + 5'h01;
          end
          if (st.use_mem && (st.kind != 3'h0)) begin
            // Column wraps to row start; no automatic row step
            if (col == LAST_COLUMN) begin
              next_st.status[ST_LAST_COL] = 1'b1;
              next_st.status[ST_ALARM]    = st.inc_col;
              if (st.inc_col) begin
                next_st.mp[PTR_X_W-1:0] = 6'h00;
              end
            end else if (st.inc_col) begin
              next_st.mp[PTR_X_W-1:0] = col + 6'h01;
            end
          end
          next_st.status[ST_BUSY] = 1'b0;
          next_st.done            = 1'b1;
          next_st.fsm             = DCD_IDLE;
        end
        default: begin
          next_st.fsm = DCD_IDLE;
        end
      endcase
    end
    // Sync bit is spliced in at the output so a mask command bites at once
    next_st.status[ST_VSYNC:0] = 3'h0;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st     <= '0;
      st.fsm <= DCD_IDLE;
      st.mp  <= MP_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  // Mask commands never wait on the memory bus, so no hold for them
  dcd_timer u_timer (
    .i_mclk   (i_mclk),
    .i_nrst   (i_nrst),
    .i_load   (tmr_load),
    .i_halves (tmr_halves),
    .i_hold   (i_suspend && st.use_mem),
    .o_done   (tmr_done)
  );

  dcd_status u_status (
    .i_mclk         (i_mclk),
    .i_nrst         (i_nrst),
    .i_mask_set     (mask_set),
    .i_mask_clear   (mask_clear),
    .i_vsync        (i_vsync),
    .o_mask         (vmask),
    .o_vsync_status (vstat)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_main_pointer = st.mp;
  assign o_status       = {st.status[ST_BUSY:ST_VSYNC+1], vstat, st.status[1:0]};
  assign o_busy         = st.status[ST_BUSY];
  assign o_mem_start    = st.mem_start;
  assign o_xfer_kind    = st.kind;
  assign o_xfer_read    = st.rd;
  assign o_vsync_mask   = vmask;
  assign o_done         = st.done;

endmodule // dcd_decoder
`default_nettype wire

// ### testbench/dcd_host.sv
`timescale 1ns/10ps
`default_nettype none
module dcd_host (
  input  wire logic        i_mclk,      // Device clock
  output logic             o_cmd_valid, // Strobe trailing edge
  output logic             o_selected,  // Latched select
  output logic             o_exec_req,  // Latched request bit
  output logic [7:0]       o_cmd,       // Command byte
  output logic             o_mp_load,   // Pointer load
  output logic [15:0]      o_mp_data    // Pointer value
);
  initial begin
    o_cmd_valid = 1'b0;
    o_selected = 1'b0;
    o_exec_req = 1'b0;
    o_cmd = 8'h00;
    o_mp_load = 1'b0;
    o_mp_data = 16'h0000;
  end
  // -----------------------------------------------------------
  // Bus cycles; a released bus shows the inverse, never a stale copy
  // -----------------------------------------------------------
  task automatic command(input logic [7:0] c, input logic s, input logic r);
    @(negedge i_mclk);
    o_cmd_valid = 1'b1;
    o_selected = s;
    o_exec_req = r;
    o_cmd = c;
    @(negedge i_mclk);
    o_cmd_valid = 1'b0;
    o_selected = 1'b0;
    o_exec_req = 1'b0;
    o_cmd = ~c;
  endtask
  task automatic load(input logic [15:0] d);
    @(negedge i_mclk);
    o_mp_load = 1'b1;
    o_mp_data = d;
    @(negedge i_mclk);
    o_mp_load = 1'b0;
    o_mp_data = ~d;
  endtask
endmodule // dcd_host
`default_nettype wire

// ### testbench/dcd_decoder_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dcd_decoder_sva
  import dcd_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  input wire logic        i_cmd_valid,
  input wire logic        i_selected,
  input wire logic        i_exec_req,
  input wire logic [7:0]  i_cmd,
  input wire logic        i_vsync,
  input wire logic        i_suspend,
  input wire logic        i_mp_load,
  input wire logic [15:0] i_mp_data,
  input wire logic [15:0] o_main_pointer,
  input wire logic [7:0]  o_status,
  input wire logic        o_busy,
  input wire logic        o_mem_start,
  input wire logic [2:0]  o_xfer_kind,
  input wire logic        o_xfer_read,
  input wire logic        o_vsync_mask,
  input wire logic        o_done
);
  logic        acc;
  logic [7:0]  cmd_q;
  logic [9:0]  since;
  logic [9:0]  susp;
  logic [15:0] mp_q;
  assign acc = i_cmd_valid && i_selected && i_exec_req;
  function automatic logic [2:0] kind_of(input logic [7:0] c);
    if (c[7:4] == 4'h0 && c[2:1] == 2'h0) return 3'h1;
    if (c[7:4] == 4'h0 && c[2:1] == 2'h1) return 3'h2;
    if (c[7:4] == 4'h4 && c[2:1] == 2'h0) return 3'h3;
    if (c[7:4] == 4'h5 && c[2:1] == 2'h0) return 3'h4;
    return 3'h0;
  endfunction
  function automatic int halves_of(input logic [7:0] c);
    case (kind_of(c))
      3'h1: return c[3] ? 15 : 8;
      3'h2: return c[3] ? 15 : 11;
      3'h3: return c[3] ? 19 : 18;
      3'h4: return c[3] ? 23 : 25;
      default: return (c == 8'hB0) ? 4 : 2;
    endcase
  endfunction
  // Suspension only stretches memory commands, so count it apart
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmd_q <= 8'h00;
      since <= 10'h000;
      susp <= 10'h000;
      mp_q <= 16'h0000;
    end else if (acc) begin
      cmd_q <= i_cmd;
      since <= 10'h000;
      susp <= 10'h000;
      mp_q <= o_main_pointer;
    end else begin
      since <= since + 10'h001;
      susp <= susp + {9'h000, i_suspend};
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence s_set; acc && i_cmd == 8'h99; endsequence
  sequence s_clr; acc && i_cmd == 8'h95; endsequence
  sequence s_xfer; acc && kind_of(i_cmd) != 3'h0; endsequence
  a_busy_start: assert property (acc |=> o_busy)
    else $error("busy not raised");
  a_ignored_strobe: assert property (
    i_cmd_valid && !(i_selected && i_exec_req) && !o_busy |=> !o_busy)
    else $error("unrequested command ran");
  a_mask_set: assert property (s_set |=> o_vsync_mask && !o_status[2])
    else $error("mask set failed");
  a_mask_clear: assert property (s_clr |=> !o_vsync_mask)
    else $error("mask clear failed");
  a_mask_gates: assert property (o_vsync_mask |-> !o_status[2])
    else $error("masked sync bit high");
  a_sync_follows: assert property ($past(i_nrst) && !o_vsync_mask
    && !$past(o_vsync_mask) |-> o_status[2] == $past(i_vsync))
    else $error("sync bit not following");
  a_busy_bit: assert property (o_busy == o_status[7])
    else $error("busy bit mismatch");
  a_xfer_start: assert property (s_xfer |=> o_mem_start
    && o_xfer_kind == kind_of(cmd_q) && o_xfer_read == cmd_q[3])
    else $error("transfer decode wrong");
  a_done_time: assert property (o_done |-> !o_busy && since ==
    halves_of(cmd_q) * 6 + 2 + ((kind_of(cmd_q) != 3'h0) ? susp : 0))
    else $error("completion time wrong");
  a_row_step: assert property (o_done && cmd_q == 8'hB0 |->
    o_main_pointer == {mp_q[15:13], mp_q[12:8] + 5'h01, mp_q[7:0]})
    else $error("row step wrong");
  a_column_flags: assert property (o_done && kind_of(cmd_q) != 3'h0 |->
    o_status[5] == (mp_q[5:0] == 6'h27)
    && o_status[6] == (mp_q[5:0] == 6'h27 && cmd_q[0]))
    else $error("column flags wrong");
endmodule // dcd_decoder_sva
bind dcd_decoder dcd_decoder_sva dcd_decoder_sva_inst (.*);
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dcd_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_nrst, i_vsync, i_suspend;
  logic        cmd_valid, selected, exec_req, mp_load;
  logic [7:0]  cmd, status;
  logic [15:0] mp_data, main_pointer;
  logic        busy, mem_start, xfer_read, vsync_mask, done;
  logic [2:0]  xfer_kind;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          t;
  logic [7:0]  codes [11] = '{8'h00, 8'h08, 8'h02, 8'h0A, 8'h40, 8'h48,
                             8'h50, 8'h58, 8'h99, 8'h95, 8'hB0};
  int          halves [11] = '{8, 15, 11, 15, 18, 19, 25, 23, 2, 2, 4};
  logic [2:0]  kinds [11] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3,
                             3'h4, 3'h4, 3'h0, 3'h0, 3'h0};
  always #25 i_mclk = ~i_mclk;
  dcd_host dcd_host_inst (.i_mclk(i_mclk), .o_cmd_valid(cmd_valid),
    .o_selected(selected), .o_exec_req(exec_req), .o_cmd(cmd),
    .o_mp_load(mp_load), .o_mp_data(mp_data));
  dcd_decoder dcd_decoder_inst (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_cmd_valid(cmd_valid), .i_selected(selected), .i_exec_req(exec_req),
    .i_cmd(cmd), .i_vsync(i_vsync), .i_suspend(i_suspend),
    .i_mp_load(mp_load), .i_mp_data(mp_data), .o_main_pointer(main_pointer),
    .o_status(status), .o_busy(busy), .o_mem_start(mem_start),
    .o_xfer_kind(xfer_kind), .o_xfer_read(xfer_read),
    .o_vsync_mask(vsync_mask), .o_done(done));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Counts cycles to completion; suspension held for the first s edges
  task automatic run(input logic [7:0] c, input int s, output int n);
    dcd_host_inst.command(c, 1'b1, 1'b1);
    n = 0;
    i_suspend = (s > 0);
    while (done !== 1'b1 && n < 1000) begin
      @(negedge i_mclk);
      n++;
      i_suspend = (n < s);
    end
    // A command that never completes must not slip through to a pass
    if (done !== 1'b1) miscompares++;
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    i_nrst = 1'b0;
    i_vsync = 1'b1;
    i_suspend = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_nrst = 1'b1;
    chk(status, 8'h00);
    for (int i = 0; i < 11; i++) begin
      run(codes[i], 0, t);
      chk(16'(t), 16'(halves[i] * 6 + 2));
      chk(xfer_kind, kinds[i]);
      chk(xfer_read, codes[i][3]);
    end
    chk(main_pointer, 16'h0100);
    chk(status, 8'h04);
    run(8'h99, 0, t);
    chk(vsync_mask, 1'b1);
    i_vsync = 1'b0;
    @(negedge i_mclk);
    i_vsync = 1'b1;
    @(negedge i_mclk);
    chk(status, 8'h00);
    run(8'h95, 0, t);
    i_vsync = 1'b0;
    @(negedge i_mclk);
    chk(status, 8'h00);
    i_vsync = 1'b1;
    @(negedge i_mclk);
    chk(status, 8'h04);
    dcd_host_inst.load(16'h0027);
    run(8'h01, 0, t);
    chk(status, 8'h64);
    chk(main_pointer, 16'h0000);
    run(8'h41, 0, t);
    chk(main_pointer, 16'h0001);
    chk(status, 8'h04);
    run(8'h50, 5, t);
    chk(16'(t), 16'h009D);
    dcd_host_inst.load(16'h0A05);
    dcd_host_inst.command(8'hB0, 1'b1, 1'b1);
    dcd_host_inst.load(16'h1F3F);
    run(8'hB0, 0, t);
    chk(16'(t), 16'h001A);
    chk(main_pointer, 16'h0B05);
    dcd_host_inst.load(16'h1F27);
    run(8'hB0, 0, t);
    chk(main_pointer, 16'h0027);
    dcd_host_inst.command(8'h99, 1'b0, 1'b1);
    dcd_host_inst.command(8'h99, 1'b1, 1'b0);
    @(negedge i_mclk);
    chk(busy, 1'b0);
    chk(vsync_mask, 1'b0);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
